//--- crc_pkg.sv
// shared constants and types for the byte stream checksum engine
package crc_pkg;
	// register byte offsets
	localparam logic [3:0] OFF_CONTROL = 4'h0;
	localparam logic [3:0] OFF_INPUT   = 4'h4;
	localparam logic [3:0] OFF_WINDOW  = 4'h8;
	localparam logic [3:0] OFF_REVERSE = 4'hc;
	// control field positions
	localparam int CTL_PTR_LSB  = 0;
	localparam int CTL_PRESET   = 2;
	localparam int CTL_INIT     = 3;
	localparam int CTL_POLYSEL  = 4;
	// polynomials
	localparam logic [15:0] POLY16     = 16'h1021;
	localparam logic [31:0] POLY32_REF = 32'hedb88320;
	// values after reset, and the byte width
	localparam logic [31:0] RESULT_RST = 32'h00000000;
	localparam logic [1:0]  PTR_RST    = 2'h0;
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam int          BYTE_BITS  = 8;
	// axi response codes
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// one buffered input byte
	typedef struct packed {
		logic [7:0] data;
	} byte_item_s;

	// axi-lite write phase state
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} wr_state_e;
endpackage

//--- byte_buffer.sv
// two-entry valid/ready buffer for input bytes
module byte_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rd;
		logic [AW-1:0]               wr;
		logic [AW:0]                 cnt;
	} buf_state_s;

	buf_state_s st_reg;
	buf_state_s st_next;
	logic       push;
	logic       pop;

	// honest full/empty from the occupancy count
	assign in_ready_o  = (st_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (st_reg.cnt != '0);
	assign out_data_o  = st_reg.mem[st_reg.rd];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// pointer and count update
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr] = in_data_i;
			st_next.wr = (st_reg.wr == AW'(DEPTH-1)) ? '0 : st_reg.wr + 1'b1;
		end
		if (pop)
			st_next.rd = (st_reg.rd == AW'(DEPTH-1)) ? '0 : st_reg.rd + 1'b1;
		if (push && !pop)
			st_next.cnt = st_reg.cnt + 1'b1;
		else if (pop && !push)
			st_next.cnt = st_reg.cnt - 1'b1;
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (srst_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule

//--- byte_stream_crc_engine.sv
// byte-serial 16/32-bit checksum engine with an axi4-lite register slave
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
module byte_stream_crc_engine (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic [3:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [3:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i
);
	import crc_pkg::*;

	// all registered state of the engine apart from the input buffer
	typedef struct packed {
		wr_state_e   wr_state;
		logic        aw_held;
		logic [3:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] result;
		logic [1:0]  ptr;
		logic        poly_sel;
		logic        preset_sel;
		logic [7:0]  last_input;
		logic [7:0]  reverse;
	} engine_state_s;

	engine_state_s st_reg;
	engine_state_s st_next;

	// byte path through the two-entry buffer
	logic       buf_in_valid;
	logic       buf_in_ready;
	logic [7:0] buf_in_data;
	logic       buf_out_valid;
	logic       buf_out_ready;
	byte_item_s buf_out;
	logic [31:0] folded;
	logic [7:0]  win_byte;
	logic [7:0]  rev_in;

	// decoded write transaction
	logic        wr_fire;
	logic        wr_low_lane;
	logic        wr_is_input;

	byte_buffer #(
		.WIDTH (BYTE_BITS),
		.DEPTH (2)
	) u_input_buffer (
		.clk_i       (clk_i),
		.srst_i      (srst_i),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (buf_in_data),
		.out_valid_o (buf_out_valid),
		.out_ready_i (buf_out_ready),
		.out_data_o  (buf_out.data)
	);

	// only the two package polynomials are ever applied
	// one-byte fold, unrolled combinationally
	function automatic logic [31:0] fold_byte(input logic [31:0] acc_in,
			input logic [7:0] din, input logic sixteen);
		logic [31:0] acc;
		logic [15:0] a16;
		acc = acc_in;
		a16 = acc_in[15:0];
		if (sixteen) begin
			a16 = a16 ^ {din, 8'h00};
			for (int i = 0; i < BYTE_BITS; i++)
				a16 = a16[15] ? ({a16[14:0], 1'b0} ^ POLY16) : {a16[14:0], 1'b0};
			acc = {acc_in[31:16], a16};
		end else begin
			acc = acc ^ {24'h000000, din};
			for (int i = 0; i < BYTE_BITS; i++)
				acc = acc[0] ? ({1'b0, acc[31:1]} ^ POLY32_REF) : {1'b0, acc[31:1]};
		end
		return acc;
	endfunction

	// reflected 32-bit form comes from lsb-first folding
	assign folded = fold_byte(st_reg.result, buf_out.data, st_reg.poly_sel);

	// in 16-bit mode pointer bit 1 is ignored
	always_comb begin
		logic [1:0] sel;
		sel = st_reg.poly_sel ? {1'b0, st_reg.ptr[0]} : st_reg.ptr;
		win_byte = st_reg.result[8*sel +: 8];
	end

	// write phase fires once both address and data are held
	assign wr_fire = st_reg.wr_state == WR_IDLE && st_reg.aw_held
		&& st_reg.w_held;
	assign wr_low_lane = st_reg.w_strb[0];
	assign wr_is_input = wr_fire && wr_low_lane
		&& st_reg.aw_addr == OFF_INPUT;

	// input writes go into the buffer; refused writes wait for room
	assign buf_in_valid = wr_is_input;
	assign buf_in_data  = st_reg.w_data[7:0];
	// the engine always drains, so the buffer only guards a same-cycle clash
	assign buf_out_ready = 1'b1;

	// bit reversal of the stored byte
	always_comb begin
		for (int i = 0; i < BYTE_BITS; i++)
			rev_in[i] = st_reg.w_data[BYTE_BITS-1-i];
	end

	assign s_axi_awready_o = !st_reg.aw_held && st_reg.wr_state == WR_IDLE;
	assign s_axi_wready_o  = !st_reg.w_held && st_reg.wr_state == WR_IDLE;
	assign s_axi_bvalid_o  = st_reg.wr_state == WR_RESP;
	assign s_axi_bresp_o   = st_reg.bresp;
	assign s_axi_arready_o = !st_reg.rvalid;
	assign s_axi_rvalid_o  = st_reg.rvalid;
	assign s_axi_rdata_o   = st_reg.rdata;
	assign s_axi_rresp_o   = st_reg.rresp;

	// next-state logic for bus slave and engine
	always_comb begin
		st_next = st_reg;
		// capture address and data in either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			st_next.w_held = 1'b1;
			st_next.w_data = s_axi_wdata_i;
			st_next.w_strb = s_axi_wstrb_i;
		end

		// every byte leaving the buffer updates the result
		// fold completes in the cycle it is taken
		if (buf_out_valid)
			st_next.result = folded;

		// execute a write only when an input byte has room
		if (wr_fire && (!wr_is_input || buf_in_ready)) begin
			st_next.aw_held  = 1'b0;
			st_next.w_held   = 1'b0;
			st_next.wr_state = WR_RESP;
			st_next.bresp    = RESP_OKAY;
			case (st_reg.aw_addr)
				OFF_CONTROL: begin
					if (wr_low_lane) begin
						st_next.poly_sel   = st_reg.w_data[CTL_POLYSEL];
						st_next.preset_sel = st_reg.w_data[CTL_PRESET];
						st_next.ptr = st_reg.w_data[CTL_PTR_LSB +: 2];
						// init loads preset into whole result
						// first byte then folds from the preset
						if (st_reg.w_data[CTL_INIT])
							st_next.result = {32{st_reg.w_data[CTL_PRESET]}};
					end
				end
				OFF_INPUT: begin
					if (wr_low_lane)
						st_next.last_input = st_reg.w_data[7:0];
				end
				OFF_WINDOW: begin
					if (wr_low_lane) begin
						if (st_reg.poly_sel)
							st_next.result[8*st_reg.ptr[0] +: 8] =
								st_reg.w_data[7:0];
						else
							st_next.result[8*st_reg.ptr +: 8] = st_reg.w_data[7:0];
						st_next.ptr = st_reg.ptr + 2'h1;
					end
				end
				OFF_REVERSE: begin
					if (wr_low_lane)
						st_next.reverse = rev_in;
				end
				default: st_next.bresp = RESP_SLVERR;
			endcase
		end
		if (st_reg.wr_state == WR_RESP && s_axi_bready_i)
			st_next.wr_state = WR_IDLE;

		// read side, one outstanding read
		if (st_reg.rvalid && s_axi_rready_i)
			st_next.rvalid = 1'b0;
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = RESP_OKAY;
			st_next.rdata  = 32'h00000000;
			case (s_axi_araddr_i)
				OFF_CONTROL: begin
					// init bit reads back as zero, it is a strobe
					st_next.rdata[CTL_POLYSEL] = st_reg.poly_sel;
					st_next.rdata[CTL_PRESET]  = st_reg.preset_sel;
					st_next.rdata[CTL_PTR_LSB +: 2] = st_reg.ptr;
				end
				OFF_INPUT:
					st_next.rdata[7:0] = st_reg.last_input;
				OFF_WINDOW: begin
					// result reached only through the window
					st_next.rdata[7:0] = win_byte;
					if (!(wr_fire && st_reg.aw_addr == OFF_WINDOW))
						st_next.ptr = st_reg.ptr + 2'h1;
				end
				OFF_REVERSE:
					st_next.rdata[7:0] = st_reg.reverse;
				default: st_next.rresp = RESP_SLVERR;
			endcase
		end
	end

	// state register, defined after reset
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_reg            <= '0;
			st_reg.wr_state   <= WR_IDLE;
			st_reg.result     <= RESULT_RST;
			st_reg.ptr        <= PTR_RST;
			st_reg.last_input <= BYTE_RST;
			st_reg.reverse    <= BYTE_RST;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

//--- byte_stream_crc_engine_asserts.sv
// bus-port checks for the checksum engine
module byte_stream_crc_engine_asserts (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_read_prompt: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> s_axi_rvalid_o) else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data not held");
	a_wresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response not held");
	a_ar_refuse: assert property (s_axi_rvalid_o
		|-> !s_axi_arready_o) else $error("read taken while busy");
	a_aw_refuse: assert property (s_axi_bvalid_o
		|-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while busy");
	a_byte_wide: assert property (s_axi_rvalid_o && s_axi_rresp_o == 2'h0
		|-> s_axi_rdata_o[31:8] == 24'h0) else $error("upper bits set");
	a_write_done: assert property (s_axi_awvalid_i && s_axi_awready_o
		&& s_axi_wvalid_i && s_axi_wready_o |-> ##[1:8] s_axi_bvalid_o)
		else $error("write never answered");
	a_reset_idle: assert property ($fell(srst_i)
		|-> !s_axi_bvalid_o && !s_axi_rvalid_o) else $error("busy after reset");
endmodule

bind byte_stream_crc_engine byte_stream_crc_engine_asserts i_chk (
	.clk_i, .srst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
	.s_axi_rvalid_o, .s_axi_rready_i);

//--- byte_stream_crc_engine_bench.sv
// self-checking bench for the checksum engine
module byte_stream_crc_engine_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import crc_pkg::*;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [3:0]  awa = 4'h0;
	logic [3:0]  ara = 4'h0;
	logic [31:0] wd = 32'h0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        br = 1'b0;
	logic        arv = 1'b0;
	logic        rr = 1'b0;
	logic        awr, wr, bv, arr, rv;
	logic [1:0]  bre, rre, rsp;
	logic [31:0] rd, got, acc;
	logic [7:0]  b, rev;
	int          failures = 0;
	int          n_tests = 0;
	int          cyc = 0;

	byte_stream_crc_engine i_dut (.clk_i(clk_i), .srst_i(srst_i),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wr), .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rre),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rr));

	// 10 mhz clock
	always #50 clk_i = ~clk_i;

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 5000) begin
			failures++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		rsp = bre;
		br <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk_i);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arr) arv <= 1'b0;
		end while (!rv);
		got = rd;
		rsp = rre;
		rr <= 1'b0;
	endtask

	// reference fold of one byte, both widths
	function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] d,
		logic s16);
		if (s16) begin
			c[15:8] ^= d;
			for (int i = 0; i < 8; i++)
				c[15:0] = {c[14:0], 1'b0} ^ (c[15] ? POLY16 : 16'h0);
		end else begin
			c[7:0] ^= d;
			for (int i = 0; i < 8; i++)
				c = (c >> 1) ^ (c[0] ? POLY32_REF : 32'h0);
		end
		return c;
	endfunction

	initial begin
		void'($urandom(32'h4f5d));
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		rd_reg(OFF_WINDOW);
		chk("reset result", got, 32'h0);
		// every width and preset, three bytes each waiting for its write response, then window sweep
		for (int m = 0; m < 4; m++) begin
			wr_reg(OFF_CONTROL, {27'h0, m[1], 1'b1, m[0], 2'h0});
			acc = m[0] ? 32'hffffffff : 32'h0;
			repeat (3) begin
				b = 8'($urandom);
				wr_reg(OFF_INPUT, {24'h0, b});
				acc = fold(acc, b, m[1]);
			end
			for (int p = 0; p < 5; p++) begin
				rd_reg(OFF_WINDOW);
				chk("window", got, {24'h0, acc[8*(m[1] ? p%2 : p%4)+:8]});
			end
		end
		// overwrite one byte through the window, then fold on top of it
		wr_reg(OFF_CONTROL, 32'h0e);
		wr_reg(OFF_WINDOW, 32'h5a);
		acc = 32'hff5affff;
		for (int p = 3; p < 7; p++) begin
			rd_reg(OFF_WINDOW);
			chk("window write", got, {24'h0, acc[8*(p%4)+:8]});
		end
		b = 8'($urandom);
		wr_reg(OFF_INPUT, {24'h0, b});
		acc = fold(acc, b, 1'b0);
		rd_reg(OFF_WINDOW);
		chk("fold after write", got, {24'h0, acc[31:24]});
		// bit reversal helper
		b = 8'($urandom);
		for (int i = 0; i < 8; i++) rev[i] = b[7-i];
		wr_reg(OFF_REVERSE, {24'h0, b});
		chk("write resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
		rd_reg(OFF_REVERSE);
		chk("reverse", got, {24'h0, rev});
		// unmapped places answer with an error
		wr_reg(4'h2, 32'h1);
		chk("bad write", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		rd_reg(4'h6);
		chk("bad read", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		complete_run();
	end
endmodule
